// ### src/pdc_pkg.sv
package pdc_pkg;
  localparam int PDC_NPORT = 11;
  typedef logic [0:PDC_NPORT-1][7:0] pdc_bank_t;
  typedef logic [0:PDC_NPORT-1][15:0] pdc_addr_tbl_t;
  // Port order: 0, 1, 3, 4, 5, 6, 7, 8, 9, 12, 13
  localparam int PDC_P13_IDX = 10;
  localparam int PDC_OUT_ONLY_BIT = 0;
  localparam pdc_addr_tbl_t PDC_DIR_OFS = {
    16'hFF20, 16'hFF21, 16'hFF23, 16'hFF24, 16'hFF25, 16'hFF26,
    16'hFF27, 16'hFF28, 16'hFF29, 16'hFF2C, 16'hFF2D};
  localparam pdc_addr_tbl_t PDC_DATA_OFS = {
    16'hFF00, 16'hFF01, 16'hFF03, 16'hFF04, 16'hFF05, 16'hFF06,
    16'hFF07, 16'hFF08, 16'hFF09, 16'hFF0C, 16'hFF0D};
  // Bits that software may change; the rest hold their fixed value
  localparam pdc_bank_t PDC_DIR_MASK = {
    8'h63, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF,
    8'h7F, 8'hFF, 8'hFF, 8'h1F, 8'h06};
  localparam pdc_bank_t PDC_DIR_RESET = {
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFE};
  localparam logic [7:0] PDC_UNMAPPED = 8'h00;
endpackage

// ### src/pdc_view_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pdc_view_if;
  import pdc_pkg::*;
  pdc_bank_t dir;
  pdc_bank_t latch;
  pdc_bank_t pin;
  pdc_bank_t value;
  modport ctrl (output dir, output latch, output pin, input value);
  modport view (input dir, input latch, input pin, output value);
endinterface
`default_nettype wire

// ### src/pdc_data_view.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_data_view
  import pdc_pkg::*;
(
  pdc_view_if.view vw // Direction, latch and pin levels in; read value out
);
  // Input-mode bits show the pin, output-mode bits show the latch
  always_comb begin
    for (int i = 0; i < PDC_NPORT; i++) begin
      vw.value[i] = (vw.dir[i] & vw.pin[i]) | (~vw.dir[i] & vw.latch[i]);
    end
  end
endmodule
`default_nettype wire

// ### src/pdc_top.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_top
  import pdc_pkg::*;
(
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [15:0] addr, // Internal bus address
  input wire logic wr_byte, // Whole-byte write strobe
  input wire logic wr_bit, // Single-bit write strobe
  input wire logic [7:0] wdata, // Byte write data
  input wire logic [2:0] bit_sel, // Bit chosen by a single-bit write
  input wire logic bit_val, // Value for a single-bit write
  input wire logic rd, // Read strobe
  input wire pdc_bank_t port_latch, // Output latch of each port
  input wire pdc_bank_t port_pin, // Pin level of each port
  output logic [7:0] rd_data, // Read data, valid the cycle after rd
  output pdc_bank_t pin_oe_n // Output enable per pin, low drives the pin
);
  typedef struct packed {
    pdc_bank_t dir;
    logic [7:0] rd_data;
  } pdc_state_t;

  typedef struct packed {
    logic hit;
    logic [3:0] idx;
  } pdc_hit_t;

  // Eleven compares side by side; a full decoder would cost more than it saves
  function automatic pdc_hit_t pdc_find(input logic [15:0] a, input pdc_addr_tbl_t tbl);
    pdc_hit_t r;
    r = '0;
    for (int i = 0; i < PDC_NPORT; i++) begin
      if (a == tbl[i]) begin
        r.hit = 1'b1;
        r.idx = 4'(i);
      end
    end
    return r;
  endfunction

  // Bits with a pad: the writable ones plus the fixed output-only bit
  function automatic logic [7:0] pdc_pinned(input logic [3:0] idx);
    return PDC_DIR_MASK[idx] | ~PDC_DIR_RESET[idx];
  endfunction

  pdc_state_t st_ff;
  pdc_state_t nxt_st;
  pdc_hit_t dir_hit;
  pdc_hit_t data_hit;
  logic [7:0] sel_dir;
  logic [7:0] sel_mask;
  logic [7:0] bit_onehot;
  logic [7:0] wr_value;

  pdc_view_if vw_if ();

  assign vw_if.dir = st_ff.dir;
  assign vw_if.latch = port_latch;
  assign vw_if.pin = port_pin;

  pdc_data_view u_view (
    .vw (vw_if.view)
  );

  always_comb begin
    dir_hit = pdc_find(addr, PDC_DIR_OFS);
    data_hit = pdc_find(addr, PDC_DATA_OFS);
    sel_dir = st_ff.dir[dir_hit.idx];
    sel_mask = PDC_DIR_MASK[dir_hit.idx];
    bit_onehot = 8'h01 << bit_sel;
    nxt_st = st_ff;
    // A bit write replaces one bit and keeps the rest of the register
    if (wr_bit) begin
      wr_value = (sel_dir & ~bit_onehot) | ({8{bit_val}} & bit_onehot);
    end else begin
      wr_value = wdata;
    end
    if ((wr_byte || wr_bit) && dir_hit.hit) begin
      // Pinless bits keep their reset value, so the fixed bits never move
      nxt_st.dir[dir_hit.idx] = (wr_value & sel_mask) | (sel_dir & ~sel_mask);
    end
    if (rd) begin
      if (dir_hit.hit) begin
        nxt_st.rd_data = sel_dir;
      end else if (data_hit.hit) begin
        // Pinless data bits read zero, whatever the floating pad shows
        nxt_st.rd_data = vw_if.value[data_hit.idx] & pdc_pinned(data_hit.idx);
      end else begin
        nxt_st.rd_data = PDC_UNMAPPED;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{dir: PDC_DIR_RESET, rd_data: PDC_UNMAPPED};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.rd_data;
  // Enable low means output mode, so the direction bit drives it directly
  assign pin_oe_n = st_ff.dir;

  // Helper logic for the checks below
  logic seen_ff;
  logic fixed_ok;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_ff <= 1'b0;
    end else begin
      seen_ff <= 1'b1;
    end
  end
  always_comb begin
    fixed_ok = 1'b1;
    for (int i = 0; i < PDC_NPORT; i++) begin
      if ((st_ff.dir[i] & ~PDC_DIR_MASK[i]) != (PDC_DIR_RESET[i] & ~PDC_DIR_MASK[i])) begin
        fixed_ok = 1'b0;
      end
    end
  end

  // seen_ff is low only on the first edge after reset
  a_reset_load: assert property (@(posedge clk) disable iff (rst)
    !seen_ff |-> pin_oe_n == PDC_DIR_RESET)
    else $error("direction registers not at reset value after reset");

  a_reset_rdata: assert property (@(posedge clk) disable iff (rst)
    !seen_ff |-> rd_data == PDC_UNMAPPED)
    else $error("read data not cleared by reset");

  a_out_only_pin: assert property (@(posedge clk) disable iff (rst)
    pin_oe_n[PDC_P13_IDX][PDC_OUT_ONLY_BIT] == 1'b0)
    else $error("output-only pin left output mode");

  a_out_only_read: assert property (@(posedge clk) disable iff (rst)
    (rd && dir_hit.hit && dir_hit.idx == 4'(PDC_P13_IDX)) |=>
      rd_data[PDC_OUT_ONLY_BIT] == 1'b0)
    else $error("output-only pin read back as an input");

  a_fixed_bits: assert property (@(posedge clk) disable iff (rst)
    fixed_ok)
    else $error("a pinless direction bit changed");

  // Fixed bits read back their reset value, never what was written
  a_fixed_read: assert property (@(posedge clk) disable iff (rst)
    (rd && dir_hit.hit) |=>
      ((rd_data ^ $past(PDC_DIR_RESET[dir_hit.idx])) & ~$past(sel_mask)) == 8'h00)
    else $error("a pinless direction bit read back a wrong value");

  a_byte_write: assert property (@(posedge clk) disable iff (rst)
    (wr_byte && !wr_bit && dir_hit.hit) |=>
      (pin_oe_n[$past(dir_hit.idx)] & $past(sel_mask)) == ($past(wdata) & $past(sel_mask)))
    else $error("byte write did not reach the direction register");

  // Read-modify-write in one cycle, so neighbours must come through untouched
  a_bit_keeps: assert property (@(posedge clk) disable iff (rst)
    (wr_bit && dir_hit.hit) |=>
      ((pin_oe_n[$past(dir_hit.idx)] ^ $past(sel_dir)) & ~$past(bit_onehot)) == 8'h00)
    else $error("bit write disturbed a neighbouring bit");

  a_bit_sets: assert property (@(posedge clk) disable iff (rst)
    (wr_bit && dir_hit.hit && (sel_mask & bit_onehot) != 8'h00) |=>
      pin_oe_n[$past(dir_hit.idx)][$past(bit_sel)] == $past(bit_val))
    else $error("bit write did not set the chosen bit");

  // Nothing but a write may move a direction bit
  a_idle_stable: assert property (@(posedge clk) disable iff (rst)
    (!wr_byte && !wr_bit) |=> $stable(pin_oe_n))
    else $error("direction changed without a write");

  // Data-register and unmapped addresses are read-only here
  a_miss_write: assert property (@(posedge clk) disable iff (rst)
    ((wr_byte || wr_bit) && !dir_hit.hit) |=> $stable(pin_oe_n))
    else $error("write outside the direction registers changed a direction bit");

  // One check per port, so a stray write shows which register it reached
  for (genvar g = 0; g < PDC_NPORT; g++) begin : g_iso
    a_port_isolated: assert property (@(posedge clk) disable iff (rst)
      ((wr_byte || wr_bit) && dir_hit.hit && dir_hit.idx != 4'(g)) |=> $stable(pin_oe_n[g]))
      else $error("write to one port changed another port's direction");
  end

  a_dir_read: assert property (@(posedge clk) disable iff (rst)
    (rd && dir_hit.hit) |=> rd_data == $past(sel_dir))
    else $error("direction read returned the wrong value");

  // Expected value rebuilt from direction, pad and latch, not from the read mux
  a_data_read: assert property (@(posedge clk) disable iff (rst)
    (rd && !dir_hit.hit && data_hit.hit) |=>
      rd_data == $past(((st_ff.dir[data_hit.idx] & port_pin[data_hit.idx])
        | (~st_ff.dir[data_hit.idx] & port_latch[data_hit.idx])) & pdc_pinned(data_hit.idx)))
    else $error("port data read mixed pin and latch wrongly");

  a_pinless_data: assert property (@(posedge clk) disable iff (rst)
    (rd && !dir_hit.hit && data_hit.hit) |=>
      (rd_data & ~$past(pdc_pinned(data_hit.idx))) == 8'h00)
    else $error("a pinless data bit did not read zero");

  a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
    (rd && !dir_hit.hit && !data_hit.hit) |=> rd_data == PDC_UNMAPPED)
    else $error("unmapped read returned a non-zero value");

  // Read data is a register: it must hold between reads
  a_rd_holds: assert property (@(posedge clk) disable iff (rst)
    !rd |=> $stable(rd_data))
    else $error("read data changed without a read");
endmodule
`default_nettype wire

// ### dv/test_port_direction_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_port_direction_control;
  import pdc_pkg::*;
  logic clk, rst, wr_byte, wr_bit, bit_val, rd, rd_q;
  logic [15:0] addr;
  logic [7:0] wdata, rd_data, d, m;
  logic [2:0] bit_sel;
  pdc_bank_t port_latch, port_pin, pin_oe_n, dir_m;
  logic [7:0] exp_q[$];
  int errors, n_checks, seed, i;
  pdc_top dut_u (.clk(clk), .rst(rst), .addr(addr), .wr_byte(wr_byte), .wr_bit(wr_bit),
    .wdata(wdata), .bit_sel(bit_sel), .bit_val(bit_val), .rd(rd), .port_latch(port_latch),
    .port_pin(port_pin), .rd_data(rd_data), .pin_oe_n(pin_oe_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(string what, logic [7:0] e, logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Strobe code is {wr_byte, wr_bit, rd}; back to back, one request a cycle
  task automatic op(logic [2:0] s, logic [15:0] a, logic [7:0] dv, logic [2:0] b, logic v);
    {wr_byte, wr_bit, rd, addr, wdata, bit_sel, bit_val} = {s, a, dv, b, v};
    @(posedge clk);
    #1;
  endtask
  task automatic rdx(logic [15:0] a, logic [7:0] e);
    exp_q.push_back(e);
    op(3'h1, a, 8'h00, 3'h0, 1'b0);
  endtask
  // Read data lands one cycle after the strobe; look once the edge has settled
  always @(posedge clk) begin
    rd_q = rd;
    #2;
    if (rd_q && exp_q.size() > 0)
      check("rd_data", exp_q.pop_front(), rd_data);
  end
  initial begin
    #100000;
    errors++;
    close_out();
  end
  initial begin
    seed = 32'h823D;
    {wr_byte, wr_bit, rd, bit_val, addr, wdata, bit_sel} = '0;
    port_latch = '0;
    port_pin = '0;
    rst = 1'b1;
    dir_m = PDC_DIR_RESET;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int k = 0; k < PDC_NPORT; k++) begin
      check("pin_oe_n", PDC_DIR_RESET[k], pin_oe_n[k]);
      rdx(PDC_DIR_OFS[k], PDC_DIR_RESET[k]);
    end
    repeat (80) begin
      i = $unsigned($random(seed)) % PDC_NPORT;
      d = 8'($random(seed));
      m = PDC_DIR_MASK[i];
      if (1'($random(seed))) begin
        dir_m[i] = (dir_m[i] & ~m) | (d & m);
        op(3'h4, PDC_DIR_OFS[i], d, 3'h0, 1'b0);
      end else begin
        if (m[d[2:0]]) dir_m[i][d[2:0]] = d[3];
        op(3'h2, PDC_DIR_OFS[i], 8'h00, d[2:0], d[3]);
      end
      rdx(PDC_DIR_OFS[i], dir_m[i]);
    end
    // Software keeps the bits of pads missing on small variants at 1
    dir_m[0][6] = 1'b1;
    op(3'h2, PDC_DIR_OFS[0], 8'h00, 3'h6, 1'b1);
    dir_m[5][3] = 1'b1;
    op(3'h2, PDC_DIR_OFS[5], 8'h00, 3'h3, 1'b1);
    dir_m[8][0] = 1'b1;
    op(3'h2, PDC_DIR_OFS[8], 8'h00, 3'h0, 1'b1);
    dir_m[PDC_P13_IDX][1] = 1'b1;
    op(3'h2, PDC_DIR_OFS[PDC_P13_IDX], 8'h00, 3'h1, 1'b1);
    for (int k = 0; k < PDC_NPORT; k++) begin
      // Latch and pin level both set before the data register is read
      port_latch[k] = 8'($random(seed));
      port_pin[k] = 8'($random(seed));
      // Pinless data bits read zero; port 13 bit 0 is a real pad
      m = PDC_DIR_MASK[k] | ~PDC_DIR_RESET[k];
      d = (dir_m[k] & port_pin[k]) | (~dir_m[k] & port_latch[k]);
      rdx(PDC_DATA_OFS[k], d & m);
    end
    op(3'h2, 16'hFF2D, 8'h00, 3'h0, 1'b1);
    rdx(16'hFF2D, dir_m[10]);
    op(3'h4, 16'hFF2A, 8'h00, 3'h0, 1'b0);
    rdx(16'hFF2A, PDC_UNMAPPED);
    repeat (2) op(3'h0, 16'h0000, 8'h00, 3'h0, 1'b0);
    for (int k = 0; k < PDC_NPORT; k++) begin
      check("pin_oe_n", dir_m[k], pin_oe_n[k]);
    end
    rdx(PDC_DIR_OFS[1], dir_m[1]);
    op(3'h0, 16'h0000, 8'h00, 3'h0, 1'b0);
    // Reset again mid-run; it is asynchronous, so no edge is needed
    rst = 1'b1;
    #1;
    for (int k = 0; k < PDC_NPORT; k++) begin
      check("pin_oe_n", PDC_DIR_RESET[k], pin_oe_n[k]);
    end
    check("rd_data", PDC_UNMAPPED, rd_data);
    @(posedge clk);
    #1;
    rst = 1'b0;
    for (int k = 0; k < PDC_NPORT; k++) begin
      rdx(PDC_DIR_OFS[k], PDC_DIR_RESET[k]);
    end
    repeat (2) op(3'h0, 16'h0000, 8'h00, 3'h0, 1'b0);
    check("pending reads", 8'h00, 8'(exp_q.size()));
    close_out();
  end
endmodule
`default_nettype wire
